/* verilog/ext_irq_consts.svh */
// register map, field positions, reset values and sense codes of the pin interrupt unit
// assumes an 8-bit register port with the addresses below
// Summary of operation
// - two sense bits pick low, change, fall, rise
// - line request needs global flag and enable
// - line sampled by clock before edge detection
// - upper group change requests when enabled
// - lower group change requests when enabled
// - detection ignores pin direction
// - group change sets group flag bit
// - line edge sets line flag bit zero
// - flags clear on service or written one
// - line flag reads zero in low mode
// - upper mask bits gate pins fifteen to eight
// - lower mask bits gate pins seven to zero
// - pin change detection for all sixteen inputs
// - low level detection without edge logic
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH
`define EPI_ADDR_ENABLE 8'h3D
`define EPI_ADDR_FLAGS 8'h3C
`define EPI_ADDR_SENSE 8'h69
`define EPI_ADDR_LO_MASK 8'h6B
`define EPI_ADDR_HI_MASK 8'h6C
`define EPI_BIT_UPPER 7
`define EPI_BIT_LOWER 6
`define EPI_BIT_EXT 0
`define EPI_BIT_SENSE_HI 1
`define EPI_BIT_SENSE_LO 0
`define EPI_RESET_BYTE 8'h00
`define EPI_SENSE_LOW 2'h0
`define EPI_SENSE_ANY 2'h1
`define EPI_SENSE_FALL 2'h2
`define EPI_SENSE_RISE 2'h3
`define EPI_WARM_CYCLES 2'h3
`endif

/* verilog/ext_irq_pkg.sv */
// types shared by the pin interrupt unit and its bench
// assumes nothing beyond a SystemVerilog compiler
package ext_irq_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic upper;
    logic lower;
    logic ext;
  } irq_vec_s;
  typedef struct packed {
    logic upper_group_enable;
    logic lower_group_enable;
    logic ext_line_zero_en;
    logic [1:0] sense_sel;
    logic [7:0] low_group_pin_mask;
    logic [7:0] high_group_pin_mask;
    logic upper_group_flag;
    logic lower_group_flag;
    logic ext_line_flag;
    logic [7:0] rdata;
  } epi_state_s;
endpackage : ext_irq_pkg

/* verilog/pin_sync_change.sv */
// two-flop synchroniser with registered level and change pulse per bit
// assumes asynchronous pins on the inputs; outputs are on SYS clock
`include "ext_irq_consts.svh"
module pin_sync_change #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] chg_o
);
  import ext_irq_pkg::*;
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
    logic [W-1:0] chg;
    logic [1:0] warm;
  } sync_state_s;
  sync_state_s q, d;
  always_comb begin
    d = q;
    d.meta = pin_i;
    d.sync = q.meta;
    d.last = q.sync;
    // no change reported until the chain holds real pin values
    d.chg = (q.warm == `EPI_WARM_CYCLES) ? (q.sync ^ q.last) : '0;
    if (q.warm != `EPI_WARM_CYCLES) begin
      d.warm = q.warm + 2'h1;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign lvl_o = q.last;
  assign chg_o = q.chg;
endmodule : pin_sync_change

/* verilog/external_pin_interrupt_unit.sv */
// external line and pin-change interrupt unit with its five registers
// assumes CPU on SYS_CLK_I; pins are asynchronous and synchronised here
`include "ext_irq_consts.svh"
module external_pin_interrupt_unit (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire ext_irq_pkg::reg_req_s REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic GLOBAL_IE_I,
  input wire logic EXT_LINE_ZERO_I,
  input wire logic [7:0] UPPER_CHANGE_INPUTS_I,
  input wire logic [7:0] LOWER_CHANGE_INPUTS_I,
  input wire ext_irq_pkg::irq_vec_s IRQ_ACK_I,
  output ext_irq_pkg::irq_vec_s IRQ_REQ_O
);
  import ext_irq_pkg::*;

  epi_state_s q, d;
  logic [15:0] grp_lvl;
  logic [15:0] grp_chg;
  logic ext_lvl;
  logic ext_chg;
  logic ext_rise;
  logic ext_fall;
  logic ext_set;
  logic upper_set;
  logic lower_set;
  logic low_mode;
  logic wr_flags;
  logic [7:0] enable_rd;
  logic [7:0] sense_rd;
  logic [7:0] flags_rd;

  function automatic logic hit(input reg_req_s r, input logic [7:0] a);
    hit = r.addr == a;
  endfunction : hit

  // the pins are read whatever their direction, so driving one as an
  // output gives software a way to raise its own request
  pin_sync_change #(
    .W(16)
  ) u_group_sync (
    .clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .pin_i({UPPER_CHANGE_INPUTS_I, LOWER_CHANGE_INPUTS_I}),
    .lvl_o(grp_lvl),
    .chg_o(grp_chg)
  );

  pin_sync_change #(
    .W(1)
  ) u_line_sync (
    .clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .pin_i(EXT_LINE_ZERO_I),
    .lvl_o(ext_lvl),
    .chg_o(ext_chg)
  );

  assign ext_rise = ext_chg & ext_lvl;
  assign ext_fall = ext_chg & ~ext_lvl;
  assign low_mode = q.sense_sel == `EPI_SENSE_LOW;

  always_comb begin
    unique case (q.sense_sel)
      `EPI_SENSE_ANY: ext_set = ext_chg;
      `EPI_SENSE_FALL: ext_set = ext_fall;
      `EPI_SENSE_RISE: ext_set = ext_rise;
      default: ext_set = 1'b0;
    endcase
  end

  // flags track masked changes even while the group is disabled
  assign upper_set = |(grp_chg[15:8] & q.high_group_pin_mask);
  assign lower_set = |(grp_chg[7:0] & q.low_group_pin_mask);
  assign wr_flags = REG_REQ_I.wr && hit(REG_REQ_I, `EPI_ADDR_FLAGS);

  always_comb begin
    enable_rd = `EPI_RESET_BYTE;
    enable_rd[`EPI_BIT_UPPER] = q.upper_group_enable;
    enable_rd[`EPI_BIT_LOWER] = q.lower_group_enable;
    enable_rd[`EPI_BIT_EXT] = q.ext_line_zero_en;
    sense_rd = `EPI_RESET_BYTE;
    sense_rd[`EPI_BIT_SENSE_HI] = q.sense_sel[1];
    sense_rd[`EPI_BIT_SENSE_LO] = q.sense_sel[0];
    flags_rd = `EPI_RESET_BYTE;
    flags_rd[`EPI_BIT_UPPER] = q.upper_group_flag;
    flags_rd[`EPI_BIT_LOWER] = q.lower_group_flag;
    flags_rd[`EPI_BIT_EXT] = q.ext_line_flag & ~low_mode;
  end

  always_comb begin
    d = q;
    // set wins over a clear in the same cycle
    d.upper_group_flag = (q.upper_group_flag
      & ~(IRQ_ACK_I.upper | (wr_flags & REG_REQ_I.wdata[`EPI_BIT_UPPER])))
      | upper_set;
    d.lower_group_flag = (q.lower_group_flag
      & ~(IRQ_ACK_I.lower | (wr_flags & REG_REQ_I.wdata[`EPI_BIT_LOWER])))
      | lower_set;
    d.ext_line_flag = (q.ext_line_flag
      & ~(IRQ_ACK_I.ext | (wr_flags & REG_REQ_I.wdata[`EPI_BIT_EXT])))
      | ext_set;
    if (REG_REQ_I.wr) begin
      if (hit(REG_REQ_I, `EPI_ADDR_ENABLE)) begin
        d.upper_group_enable = REG_REQ_I.wdata[`EPI_BIT_UPPER];
        d.lower_group_enable = REG_REQ_I.wdata[`EPI_BIT_LOWER];
        d.ext_line_zero_en = REG_REQ_I.wdata[`EPI_BIT_EXT];
      end
      if (hit(REG_REQ_I, `EPI_ADDR_SENSE)) begin
        d.sense_sel = {REG_REQ_I.wdata[`EPI_BIT_SENSE_HI], REG_REQ_I.wdata[`EPI_BIT_SENSE_LO]};
      end
      if (hit(REG_REQ_I, `EPI_ADDR_LO_MASK)) begin
        d.low_group_pin_mask = REG_REQ_I.wdata;
      end
      if (hit(REG_REQ_I, `EPI_ADDR_HI_MASK)) begin
        d.high_group_pin_mask = REG_REQ_I.wdata;
      end
    end
    // flag stays cleared in low-level mode
    if (d.sense_sel == `EPI_SENSE_LOW) begin
      d.ext_line_flag = 1'b0;
    end
    // read data stand for one cycle only; unmapped reads give zero
    d.rdata = `EPI_RESET_BYTE;
    if (REG_REQ_I.rd) begin
      unique case (REG_REQ_I.addr)
        `EPI_ADDR_ENABLE: d.rdata = enable_rd;
        `EPI_ADDR_SENSE: d.rdata = sense_rd;
        `EPI_ADDR_FLAGS: d.rdata = flags_rd;
        `EPI_ADDR_LO_MASK: d.rdata = q.low_group_pin_mask;
        `EPI_ADDR_HI_MASK: d.rdata = q.high_group_pin_mask;
        default: d.rdata = `EPI_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA_O = q.rdata;

  // requests are levels; a pending flag waits for its gates to open
  assign IRQ_REQ_O.upper = GLOBAL_IE_I & q.upper_group_enable & q.upper_group_flag;
  assign IRQ_REQ_O.lower = GLOBAL_IE_I & q.lower_group_enable & q.lower_group_flag;
  // low level asks straight from the synchronised pin, no edge logic;
  // a pulse that ends before the CPU takes it is lost by design
  assign IRQ_REQ_O.ext = GLOBAL_IE_I & q.ext_line_zero_en
    & (low_mode ? ~ext_lvl : q.ext_line_flag);

  sequence s_rise_seen;
    q.sense_sel == `EPI_SENSE_RISE && ext_rise;
  endsequence

  sequence s_fall_seen;
    q.sense_sel == `EPI_SENSE_FALL && ext_fall;
  endsequence

  sequence s_upper_held;
    q.upper_group_flag && !(GLOBAL_IE_I && q.upper_group_enable);
  endsequence

  sequence s_upper_opened;
    GLOBAL_IE_I && q.upper_group_enable && q.upper_group_flag;
  endsequence

  sequence s_lower_held;
    q.lower_group_flag && !(GLOBAL_IE_I && q.lower_group_enable);
  endsequence

  sequence s_lower_opened;
    GLOBAL_IE_I && q.lower_group_enable && q.lower_group_flag;
  endsequence

  // line flag only carries the request outside low-level mode
  sequence s_line_opened;
    !low_mode && GLOBAL_IE_I && q.ext_line_zero_en && q.ext_line_flag;
  endsequence

  a_rise_flag: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    s_rise_seen ##0 (REG_REQ_I.addr != `EPI_ADDR_SENSE || !REG_REQ_I.wr) |=> q.ext_line_flag)
    else $error("rising edge did not set line flag");

  a_fall_flag: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    s_fall_seen ##0 (REG_REQ_I.addr != `EPI_ADDR_SENSE || !REG_REQ_I.wr) |=> q.ext_line_flag)
    else $error("falling edge did not set line flag");

  a_edge_ignored: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    q.sense_sel == `EPI_SENSE_RISE && !ext_rise && !q.ext_line_flag
      && !REG_REQ_I.wr |=> !q.ext_line_flag)
    else $error("line flag set without a rising edge");

  a_pin_to_flag: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    q.sense_sel == `EPI_SENSE_ANY && !REG_REQ_I.wr && ext_chg
      |=> q.ext_line_flag)
    else $error("change on line lost");

  a_line_gate: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    IRQ_REQ_O.ext |-> GLOBAL_IE_I && q.ext_line_zero_en)
    else $error("line request without both gates");

  a_low_request: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    low_mode && GLOBAL_IE_I && q.ext_line_zero_en |-> IRQ_REQ_O.ext == !ext_lvl)
    else $error("low level request wrong");

  a_upper_set: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    upper_set |=> q.upper_group_flag)
    else $error("upper change did not set flag");

  a_lower_mask: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    grp_chg[7:0] != 8'h00 && (grp_chg[7:0] & q.low_group_pin_mask) == 8'h00
      && !q.lower_group_flag |=> !q.lower_group_flag)
    else $error("masked lower pin set flag");

  a_w1c_clear: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    wr_flags && REG_REQ_I.wdata[`EPI_BIT_LOWER] && !lower_set |=> !q.lower_group_flag)
    else $error("written one did not clear lower flag");

  a_ack_clear: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    IRQ_ACK_I.upper && !upper_set |=> !q.upper_group_flag ##0 !IRQ_REQ_O.upper)
    else $error("service did not clear upper flag");

  a_low_reads_zero: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    REG_REQ_I.rd && REG_REQ_I.addr == `EPI_ADDR_FLAGS && low_mode
      |=> REG_RDATA_O[`EPI_BIT_EXT] == 1'b0)
    else $error("line flag visible in low mode");

  a_pending_serviced: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    s_upper_held ##1 s_upper_opened |-> IRQ_REQ_O.upper)
    else $error("pending upper flag not requested");

  a_read_idle: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    !$past(REG_REQ_I.rd) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside answer cycle");

  a_upper_gate: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    IRQ_REQ_O.upper |-> GLOBAL_IE_I && q.upper_group_enable)
    else $error("upper request without both gates");

  a_lower_gate: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    IRQ_REQ_O.lower |-> GLOBAL_IE_I && q.lower_group_enable)
    else $error("lower request without both gates");

  a_lower_set: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    lower_set |=> q.lower_group_flag)
    else $error("lower change did not set flag");

  a_upper_mask: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    grp_chg[15:8] != 8'h00 && (grp_chg[15:8] & q.high_group_pin_mask) == 8'h00
      && !q.upper_group_flag |=> !q.upper_group_flag)
    else $error("masked upper pin set flag");

  a_upper_w1c: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    wr_flags && REG_REQ_I.wdata[`EPI_BIT_UPPER] && !upper_set |=> !q.upper_group_flag)
    else $error("written one did not clear upper flag");

  a_line_w1c: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    wr_flags && REG_REQ_I.wdata[`EPI_BIT_EXT] && !ext_set |=> !q.ext_line_flag)
    else $error("written one did not clear line flag");

  a_zero_write_keeps: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    wr_flags && !REG_REQ_I.wdata[`EPI_BIT_LOWER] && !IRQ_ACK_I.lower
      && q.lower_group_flag |=> q.lower_group_flag)
    else $error("written zero cleared lower flag");

  a_lower_ack: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    IRQ_ACK_I.lower && !lower_set |=> !q.lower_group_flag ##0 !IRQ_REQ_O.lower)
    else $error("service did not clear lower flag");

  a_line_ack: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    IRQ_ACK_I.ext && !ext_set |=> !q.ext_line_flag)
    else $error("service did not clear line flag");

  a_low_flag_zero: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    low_mode |-> !q.ext_line_flag)
    else $error("line flag held in low mode");

  a_fall_ignored: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    q.sense_sel == `EPI_SENSE_FALL && !ext_fall && !q.ext_line_flag
      && !REG_REQ_I.wr |=> !q.ext_line_flag)
    else $error("line flag set without a falling edge");

  a_sense_write: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    REG_REQ_I.wr && REG_REQ_I.addr == `EPI_ADDR_SENSE
      |=> q.sense_sel == $past(REG_REQ_I.wdata[`EPI_BIT_SENSE_HI:`EPI_BIT_SENSE_LO]))
    else $error("sense write not taken");

  a_enable_write: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    REG_REQ_I.wr && REG_REQ_I.addr == `EPI_ADDR_ENABLE
      |=> q.ext_line_zero_en == $past(REG_REQ_I.wdata[`EPI_BIT_EXT]))
    else $error("line enable write not taken");

  a_line_request: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    s_line_opened |-> IRQ_REQ_O.ext)
    else $error("gated line flag not requested");

  a_lower_pending: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    s_lower_held ##1 s_lower_opened |-> IRQ_REQ_O.lower)
    else $error("pending lower flag not requested");

  a_line_flag_cause: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    $rose(q.ext_line_flag) |-> $past(ext_set))
    else $error("line flag set without a line event");

  a_upper_flag_cause: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    $rose(q.upper_group_flag) |-> $past(upper_set))
    else $error("upper flag set without a change");

  a_lower_flag_cause: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    $rose(q.lower_group_flag) |-> $past(lower_set))
    else $error("lower flag set without a change");

  a_mask_readback: assert property (
    @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
    REG_REQ_I.rd && REG_REQ_I.addr == `EPI_ADDR_LO_MASK
      |=> REG_RDATA_O == $past(q.low_group_pin_mask))
    else $error("lower mask read back wrong");
endmodule : external_pin_interrupt_unit

/* sim/cpu_vector_model.sv */
// far side of the unit: cpu vector logic that enters one pending vector at a time
// assumes level requests on the system clock; take_i lets the bench hold service off
module cpu_vector_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic take_i,
  input wire ext_irq_pkg::irq_vec_s req_i,
  output ext_irq_pkg::irq_vec_s ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ext_irq_pkg::*;
  // one-cycle entry pulse; no second entry while the last one is in flight
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_o <= '0;
    end else begin
      ack_o <= '0;
      if (take_i && ack_o == '0) begin
        if (req_i.ext) ack_o.ext <= 1'b1;
        else if (req_i.lower) ack_o.lower <= 1'b1;
        else if (req_i.upper) ack_o.upper <= 1'b1;
      end
    end
  end
endmodule : cpu_vector_model

/* sim/external_pin_interrupt_unit_tb.sv */
// bench for the pin interrupt unit: register tasks and pin scenarios
// assumes read data one cycle after the strobe and flags four edges after a pin change
`include "ext_irq_consts.svh"
module external_pin_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_irq_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata;
  logic gie = 1'b0;
  logic line = 1'b1;
  logic [7:0] up_pins = 8'h00;
  logic [7:0] lo_pins = 8'h00;
  logic take = 1'b0;
  irq_vec_s ack;
  irq_vec_s irq;
  int failures = 0;
  int checks = 0;
  logic [7:0] addrs [6] = '{`EPI_ADDR_ENABLE, `EPI_ADDR_FLAGS, `EPI_ADDR_SENSE,
                            `EPI_ADDR_LO_MASK, `EPI_ADDR_HI_MASK, 8'h00};
  always #5 clk = ~clk;
  external_pin_interrupt_unit external_pin_interrupt_unit_i (
    .SYS_CLK_I(clk), .ARST_N_I(arst_n), .REG_REQ_I(req), .REG_RDATA_O(rdata),
    .GLOBAL_IE_I(gie), .EXT_LINE_ZERO_I(line), .UPPER_CHANGE_INPUTS_I(up_pins),
    .LOWER_CHANGE_INPUTS_I(lo_pins), .IRQ_ACK_I(ack), .IRQ_REQ_O(irq));
  cpu_vector_model cpu_vector_model_i (
    .clk_i(clk), .arst_n_i(arst_n), .take_i(take), .req_i(irq), .ack_o(ack));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask : rd
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #200us;
    failures++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    wr(`EPI_ADDR_ENABLE, 8'hFF);
    rd(`EPI_ADDR_ENABLE, 8'hC1);
    wr(`EPI_ADDR_SENSE, 8'hFF);
    rd(`EPI_ADDR_SENSE, 8'h03);
    wr(`EPI_ADDR_LO_MASK, 8'hA5);
    rd(`EPI_ADDR_LO_MASK, 8'hA5);
    wr(`EPI_ADDR_HI_MASK, 8'h5A);
    rd(`EPI_ADDR_HI_MASK, 8'h5A);
    for (int g = 0; g < 2; g++) begin
      wr(g ? `EPI_ADDR_HI_MASK : `EPI_ADDR_LO_MASK, 8'h01);
      wr(`EPI_ADDR_ENABLE, g ? 8'h80 : 8'h40);
      if (g) up_pins <= up_pins ^ 8'h02;
      else lo_pins <= lo_pins ^ 8'h02;
      settle();
      rd(`EPI_ADDR_FLAGS, 8'h00);
      if (g) up_pins <= up_pins ^ 8'h01;
      else lo_pins <= lo_pins ^ 8'h01;
      settle();
      rd(`EPI_ADDR_FLAGS, g ? 8'h80 : 8'h40);
      chk({5'h00, irq}, 8'h00);
      gie <= 1'b1;
      @(posedge clk);
      #1 chk({5'h00, irq}, g ? 8'h04 : 8'h02);
      @(posedge clk);
      take <= 1'b1;
      repeat (3) @(posedge clk);
      take <= 1'b0;
      gie <= 1'b0;
      rd(`EPI_ADDR_FLAGS, 8'h00);
    end
    wr(`EPI_ADDR_ENABLE, 8'h01);
    for (int s = 1; s < 4; s++) begin
      wr(`EPI_ADDR_SENSE, s[7:0]);
      for (int e = 0; e < 2; e++) begin
        line <= e[0];
        settle();
        rd(`EPI_ADDR_FLAGS, (s == 1 || s == 2 + e) ? 8'h01 : 8'h00);
        chk({5'h00, irq}, 8'h00);
        wr(`EPI_ADDR_FLAGS, 8'h00);
        rd(`EPI_ADDR_FLAGS, (s == 1 || s == 2 + e) ? 8'h01 : 8'h00);
        wr(`EPI_ADDR_FLAGS, 8'h01);
        rd(`EPI_ADDR_FLAGS, 8'h00);
      end
    end
    // rising edge left pending, then served through the line vector
    line <= 1'b0;
    settle();
    line <= 1'b1;
    settle();
    chk({5'h00, irq}, 8'h00);
    gie <= 1'b1;
    @(posedge clk);
    #1 chk({5'h00, irq}, 8'h01);
    @(posedge clk);
    take <= 1'b1;
    repeat (3) @(posedge clk);
    take <= 1'b0;
    gie <= 1'b0;
    rd(`EPI_ADDR_FLAGS, 8'h00);
    wr(`EPI_ADDR_SENSE, 8'h00);
    line <= 1'b0; // held low well past the sampling
    settle();
    rd(`EPI_ADDR_FLAGS, 8'h00);
    gie <= 1'b1;
    @(posedge clk);
    #1 chk({5'h00, irq}, 8'h01);
    @(posedge clk);
    line <= 1'b1;
    settle();
    chk({5'h00, irq}, 8'h00);
    gie <= 1'b0;
    final_report();
  end
endmodule : external_pin_interrupt_unit_tb
